// File: core/cmos_core.sv
// CAN message object scheduler: one object, APB registers, frame ports
// Assumes a CAN controller on pclk that hands over matched frames and
// takes transmit frames by valid/ready
//
// Behaviour
// RL1 - Periodic types send every period in milliseconds; zero period is invalid
// RL2 - Receive-unsolicited and answer-only types flag timeout when no frame within period
// RL3 - On-request types keep at least one period between transmissions; the on-request transmit type sends remote answers without the gap check
// RL4 - Read queue never holds more than its configured depth
// RL5 - Write queue never holds more than its configured depth
// RL6 - Duplicate suppression queues only data that differs from last queued
// RL7 - Every received data frame restarts the watchdog
// RL8 - Duplicate suppression only matters for receiving types
// RL9 - Receive-unsolicited queues matching data frames, ignores remote answering
// RL10 - Periodic poll sends remote frame each period, queues the answer
// RL11 - Periodic poll holds off when a remote frame got no answer
// RL12 - Poll-on-request sends one remote frame per host write request
// RL13 - Periodic transmit resends last entry each period until new data
// RL14 - Periodic transmit sends nothing until the first frame is written
// RL15 - Periodic transmit answers remote frames with previous period data
// RL16 - Answer-only type sends queued data only after a matching remote
// RL17 - Every transmitted frame carries the configured byte count
// RL18 - Remote answering off ignores all remote frames for the identifier; the answer-only type answers them whatever the answering bit
// RL19 - Communication type is a small enumerated field, one code per behaviour
//
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "cmos_regs.svh"
module cmos_core #(
  parameter int unsigned MS_CYCLES = `CMOS_MS_NS / `CMOS_CLK_NS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_valid,
  input cmos_pkg::cmos_frame_t rx_frame,
  output logic tx_valid,
  output cmos_pkg::cmos_frame_t tx_frame,
  input wire logic tx_ready,
  output logic irq
);
  import cmos_pkg::*;

  cmos_state_t s;
  cmos_state_t n;
  cmos_frame_t base;
  logic wr;
  logic rd;
  logic hit;
  logic tick;
  logic expire;
  logic wd_hit;
  logic gap_ok;
  logic can_tx;
  logic rx_data;
  logic rx_rem;
  logic rx_type;
  logic rq_pop;
  logic wq_pop;
  logic [2:0] rc;
  logic [2:0] wc;
  logic [2:0] rcap;
  logic [2:0] wcap;
  logic [5:0] ev;

  always_comb
  begin
    case (paddr)
      `CMOS_CTRL, `CMOS_ID, `CMOS_PERIOD, `CMOS_CFG, `CMOS_WLO, `CMOS_WHI,
      `CMOS_RLO, `CMOS_RHI, `CMOS_STAT, `CMOS_ISTAT, `CMOS_IMASK: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  always_comb
  begin
    n = s;
    ev = 6'h00;
    wq_pop = 1'b0;
    wr = psel && penable && pwrite;
    rd = psel && penable && !pwrite;
    tick = (s.div == 16'(MS_CYCLES - 1));
    n.div = tick ? 16'h0000 : s.div + 16'h0001;
    if (tick && s.elapsed != 16'hFFFF)
      n.elapsed = s.elapsed + 16'h0001;
    expire = tick && s.period != 16'h0000 && ({1'b0, s.elapsed} + 17'h0_0001 >= {1'b0, s.period});
    wd_hit = expire;
    gap_ok = (s.period == 16'h0000) || (s.elapsed >= s.period);
    rx_data = rx_valid && rx_frame.id == s.id && rx_frame.ext == s.ext && !rx_frame.rtr;
    rx_rem = rx_valid && rx_frame.id == s.id && rx_frame.ext == s.ext && rx_frame.rtr;
    rx_type = s.ctype == CT_RX_UNSOL || s.ctype == CT_RX_PER || s.ctype == CT_RX_CALL;
    rcap = (s.rq_len > `CMOS_QMAX) ? `CMOS_QMAX : s.rq_len;
    wcap = (s.wq_len > `CMOS_QMAX) ? `CMOS_QMAX : s.wq_len;
    base.ext = s.ext;
    base.id = s.id;
    base.rtr = 1'b0;
    base.dlc = s.dlc; // see RL17
    base.data = 64'h0000_0000_0000_0000;
    // Transmit handshake
    if (s.txv && tx_ready)
    begin
      n.txv = 1'b0;
      ev[`CMOS_EV_TXD] = 1'b1;
    end
    can_tx = s.start && !s.txv;
    // Host pop of the read queue
    rq_pop = rd && paddr == `CMOS_RHI && s.rq_cnt != 3'd0;
    if (rq_pop)
    begin
      for (int i = 0; i < 3; i++)
        n.rq[i] = s.rq[i + 1];
    end
    rc = s.rq_cnt - {2'b00, rq_pop};
    n.rq_cnt = rc;
    // Received data into the read queue
    if (s.start && rx_type && rx_data) // see RL9
    begin
      if (s.ctype == CT_RX_UNSOL)
        {n.elapsed, n.div} = 32'h0000_0000; // see RL7
      if (s.dup && s.prev_ok && rx_frame.data == s.prev_rx) // see RL6, RL8
        n.rq_cnt = rc;
      else if (rc < rcap) // see RL4
      begin
        n.rq[rc[1:0]] = rx_frame.data;
        n.rq_cnt = rc + 3'd1;
        n.prev_rx = rx_frame.data;
        n.prev_ok = 1'b1;
        ev[`CMOS_EV_RXQ] = 1'b1;
      end
      else
        ev[`CMOS_EV_RQOVF] = 1'b1;
    end
    if (s.start)
    begin
      case (s.ctype) // see RL19
        CT_RX_UNSOL:
        begin
          if (wd_hit && !rx_data)
          begin
            ev[`CMOS_EV_TMO] = 1'b1; // see RL2
            n.elapsed = 16'h0000;
          end
        end
        CT_RX_PER:
        begin
          if (rx_data)
          begin
            n.await = 1'b0;
            n.hold = 1'b0;
          end
          else if (expire)
          begin
            n.elapsed = 16'h0000;
            if (s.await)
              n.hold = 1'b1; // see RL11
            else if (!s.hold && can_tx)
            begin
              n.txv = 1'b1; // see RL10
              n.txf = base;
              n.txf.rtr = 1'b1;
              n.await = 1'b1;
            end
          end
        end
        CT_RX_CALL:
        begin
          if (s.poll && gap_ok && can_tx) // see RL3, RL12
          begin
            n.txv = 1'b1;
            n.txf = base;
            n.txf.rtr = 1'b1;
            n.poll = 1'b0;
            {n.elapsed, n.div} = 32'h0000_0000;
          end
        end
        CT_TX_PER:
        begin
          if (expire && can_tx)
          begin
            n.elapsed = 16'h0000;
            if (s.wq_cnt != 3'd0)
            begin
              wq_pop = 1'b1;
              n.last = s.wq[0];
              n.last_ok = 1'b1;
              n.txv = 1'b1;
              n.txf = base;
              n.txf.data = s.wq[0];
            end
            else if (s.last_ok) // see RL13, RL14
            begin
              n.txv = 1'b1;
              n.txf = base;
              n.txf.data = s.last;
            end
          end
          else if (expire)
            n.elapsed = 16'h0000;
          else if (rx_rem && s.ans && s.last_ok && can_tx) // see RL15, RL18
          begin
            n.txv = 1'b1;
            n.txf = base;
            n.txf.data = s.last;
          end
        end
        CT_TX_CALL:
        begin
          if (s.wq_cnt != 3'd0 && gap_ok && can_tx) // see RL3
          begin
            wq_pop = 1'b1;
            n.last = s.wq[0];
            n.last_ok = 1'b1;
            n.txv = 1'b1;
            n.txf = base;
            n.txf.data = s.wq[0];
            {n.elapsed, n.div} = 32'h0000_0000;
          end
          else if (rx_rem && s.ans && s.last_ok && can_tx) // see RL18
          begin
            n.txv = 1'b1;
            n.txf = base;
            n.txf.data = s.last;
          end
        end
        CT_TX_RESP:
        begin
          if (rx_rem)
          begin
            {n.elapsed, n.div} = 32'h0000_0000;
            if (s.wq_cnt != 3'd0 && can_tx) // see RL16
            begin
              wq_pop = 1'b1;
              n.txv = 1'b1;
              n.txf = base;
              n.txf.data = s.wq[0];
            end
          end
          else if (wd_hit)
          begin
            ev[`CMOS_EV_TMO] = 1'b1; // see RL2
            n.elapsed = 16'h0000;
          end
        end
        CT_TX_WAVE:
        begin
          if (expire)
            n.elapsed = 16'h0000;
          if (expire && can_tx && s.wq_cnt != 3'd0)
          begin
            n.txv = 1'b1;
            n.txf = base;
            n.txf.data = s.wq[s.wave];
            n.wave = ({1'b0, s.wave} + 3'd1 >= s.wq_cnt) ? 2'd0 : s.wave + 2'd1;
          end
        end
        default:
          n.txv = n.txv;
      endcase
      if (tick && s.period == 16'h0000 &&
          (s.ctype == CT_RX_PER || s.ctype == CT_TX_PER || s.ctype == CT_TX_WAVE))
        ev[`CMOS_EV_BADPER] = 1'b1; // see RL1
    end
    if (wq_pop)
    begin
      for (int i = 0; i < 3; i++)
        n.wq[i] = s.wq[i + 1];
    end
    wc = s.wq_cnt - {2'b00, wq_pop};
    n.wq_cnt = wc;
    // Register writes
    if (wr)
    begin
      case (paddr)
        `CMOS_CTRL:
        begin
          n.ctype = cmos_ctype_t'(pwdata[`CMOS_F_TYPE]);
          n.dup = pwdata[`CMOS_F_DUP];
          n.ans = pwdata[`CMOS_F_ANS];
          n.start = pwdata[`CMOS_F_START];
          n.ext = pwdata[`CMOS_F_EXT];
          n.hold = 1'b0;
          n.await = 1'b0;
          n.poll = 1'b0;
          n.wave = 2'd0;
          {n.elapsed, n.div} = 32'h0000_0000; // Restart realigns the ms divider too
        end
        `CMOS_ID: n.id = pwdata[28:0];
        `CMOS_PERIOD: n.period = pwdata[15:0];
        `CMOS_CFG:
        begin
          n.dlc = pwdata[`CMOS_F_DLC];
          n.rq_len = pwdata[`CMOS_F_RQLEN];
          n.wq_len = pwdata[`CMOS_F_WQLEN];
        end
        `CMOS_WLO: n.wlo = pwdata;
        `CMOS_WHI:
        begin
          if (s.ctype == CT_RX_CALL)
            n.poll = 1'b1; // see RL12
          else if (rx_type || (s.ctype == CT_TX_WAVE && s.start) || wc >= wcap)
            ev[`CMOS_EV_WQOVF] = 1'b1; // see RL5
          else
          begin
            n.wq[wc[1:0]] = {pwdata, s.wlo};
            n.wq_cnt = wc + 3'd1;
          end
        end
        `CMOS_IMASK: n.imask = pwdata[5:0];
        default: n.wlo = n.wlo;
      endcase
    end
    // Sticky events, set wins over write-one-clear
    n.ist = (s.ist & ~((wr && paddr == `CMOS_ISTAT) ? pwdata[5:0] : 6'h00)) | ev;
    // Read data captured in the setup cycle
    if (psel && !penable && !pwrite)
    begin
      case (paddr)
        `CMOS_CTRL: n.rdata = {25'h000_0000, s.ext, s.start, s.ans, s.dup, s.ctype};
        `CMOS_ID: n.rdata = {3'h0, s.id};
        `CMOS_PERIOD: n.rdata = {16'h0000, s.period};
        `CMOS_CFG: n.rdata = {21'h00_0000, s.wq_len, 1'b0, s.rq_len, s.dlc};
        `CMOS_WLO: n.rdata = s.wlo;
        `CMOS_RLO: n.rdata = s.rq[0][31:0];
        `CMOS_RHI: n.rdata = s.rq[0][63:32];
        `CMOS_STAT: n.rdata = {22'h00_0000, s.await, s.hold, 1'b0, s.wq_cnt, 1'b0, s.rq_cnt};
        `CMOS_ISTAT: n.rdata = {26'h000_0000, s.ist};
        `CMOS_IMASK: n.rdata = {26'h000_0000, s.imask};
        default: n.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s <= '0;
      s.rq_len <= 3'd4;
      s.wq_len <= 3'd4;
      s.dlc <= 4'h8;
    end
    else
      s <= n;
  end

  assign prdata = s.rdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign tx_valid = s.txv;
  assign tx_frame = s.txf;
  assign irq = |(s.ist & s.imask);

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_zero_period: assert property ( // see RL1
    $rose(tx_valid) && s.ctype == CT_TX_PER |-> $past(s.period) != 16'h0000)
    else $error("periodic send with zero period");
  chk_wd_timeout: assert property ( // see RL2
    s.start && s.ctype == CT_RX_UNSOL && wd_hit && !rx_data |=> s.ist[`CMOS_EV_TMO])
    else $error("watchdog expiry not flagged");
  chk_min_gap: assert property ( // see RL3
    $rose(tx_valid) && s.ctype == CT_TX_CALL && $past(s.period) != 16'h0000
    |-> $past(s.elapsed) >= $past(s.period))
    else $error("on-request send inside minimum gap");
  chk_rq_depth: assert property ( // see RL4
    (s.rq_cnt <= `CMOS_QMAX) and (rx_data && rc >= rcap |=> s.rq_cnt == $past(rc)))
    else $error("read queue beyond depth");
  chk_wq_depth: assert property ( // see RL5
    s.wq_cnt <= `CMOS_QMAX && (s.wq_cnt <= s.wq_len || $stable(s.wq_len) == 1'b0 || s.wq_cnt <= $past(s.wq_cnt)))
    else $error("write queue beyond depth");
  chk_dup_drop: assert property ( // see RL6
    s.start && s.ctype == CT_RX_UNSOL && s.dup && s.prev_ok && rx_data
    && rx_frame.data == s.prev_rx && !rq_pop |=> $stable(s.rq_cnt))
    else $error("duplicate frame queued");
  chk_wd_restart: assert property ( // see RL7
    s.start && s.ctype == CT_RX_UNSOL && rx_data && !wr |=> s.elapsed == 16'h0000)
    else $error("watchdog not restarted by data frame");
  chk_tx_no_rq: assert property ( // see RL8
    !rx_type |=> s.rq_cnt <= $past(s.rq_cnt))
    else $error("transmit type queued received data");
  chk_hold_poll: assert property ( // see RL11
    $rose(tx_valid) && s.ctype == CT_RX_PER |-> !$past(s.hold) && tx_frame.rtr)
    else $error("remote poll sent while held");
  chk_dlc: assert property ( // see RL17
    $rose(tx_valid) |-> tx_frame.dlc == $past(s.dlc))
    else $error("wrong length code");
  chk_no_answer: assert property ( // see RL18
    s.start && s.ctype == CT_TX_CALL && !s.ans && rx_rem && !s.txv && !(s.wq_cnt != 3'd0 && gap_ok)
    |=> !tx_valid)
    else $error("remote frame answered while disabled");
endmodule // cmos_core

// File: inc/cmos_regs.svh
// Register map, field positions and timing counts of the message object scheduler
// Assumes a 32-bit APB slave with word-aligned registers
`ifndef CMOS_REGS_SVH
`define CMOS_REGS_SVH
`define CMOS_CTRL 12'h000
`define CMOS_ID 12'h004
`define CMOS_PERIOD 12'h008
`define CMOS_CFG 12'h00C
`define CMOS_WLO 12'h010
`define CMOS_WHI 12'h014
`define CMOS_RLO 12'h018
`define CMOS_RHI 12'h01C
`define CMOS_STAT 12'h020
`define CMOS_ISTAT 12'h024
`define CMOS_IMASK 12'h028
// Control fields
`define CMOS_F_TYPE 2:0
`define CMOS_F_DUP 3
`define CMOS_F_ANS 4
`define CMOS_F_START 5
`define CMOS_F_EXT 6
// Config fields
`define CMOS_F_DLC 3:0
`define CMOS_F_RQLEN 6:4
`define CMOS_F_WQLEN 10:8
// Event bits
`define CMOS_EV_RXQ 0
`define CMOS_EV_TXD 1
`define CMOS_EV_TMO 2
`define CMOS_EV_RQOVF 3
`define CMOS_EV_WQOVF 4
`define CMOS_EV_BADPER 5
`define CMOS_EVW 6
// Queue storage and reset values
`define CMOS_QMAX 3'd4
`define CMOS_CFG_RST 11'h448
// Period unit and clock period
`define CMOS_MS_NS 1000000
`define CMOS_CLK_NS 20
`endif

// File: inc/cmos_pkg.sv
// Types of the message object scheduler
// Assumes cmos_regs.svh for constants
package cmos_pkg;
  typedef enum logic [2:0] {
    CT_RX_UNSOL = 3'b000,
    CT_RX_PER = 3'b001,
    CT_RX_CALL = 3'b010,
    CT_TX_PER = 3'b011,
    CT_TX_CALL = 3'b100,
    CT_TX_RESP = 3'b101,
    CT_TX_WAVE = 3'b110
  } cmos_ctype_t;

  typedef struct packed {
    logic ext;
    logic [28:0] id;
    logic rtr;
    logic [3:0] dlc;
    logic [63:0] data;
  } cmos_frame_t;

  typedef struct packed {
    cmos_ctype_t ctype;
    logic dup;
    logic ans;
    logic start;
    logic ext;
    logic [28:0] id;
    logic [15:0] period;
    logic [3:0] dlc;
    logic [2:0] rq_len;
    logic [2:0] wq_len;
    logic [31:0] wlo;
    logic [3:0][63:0] rq;
    logic [2:0] rq_cnt;
    logic [3:0][63:0] wq;
    logic [2:0] wq_cnt;
    logic [63:0] last;
    logic last_ok;
    logic [63:0] prev_rx;
    logic prev_ok;
    logic [15:0] div;
    logic [15:0] elapsed;
    logic hold;
    logic await;
    logic poll;
    logic [1:0] wave;
    logic txv;
    cmos_frame_t txf;
    logic [5:0] ist;
    logic [5:0] imask;
    logic [31:0] rdata;
  } cmos_state_t;
endpackage

// File: bench/cmos_node.sv
// Network side model: takes object frames, answers remote polls
// Assumes the object's frame ports, all on pclk
`timescale 1ns/1ps
module cmos_node (
  input wire logic pclk,
  input wire logic tx_valid,
  input cmos_pkg::cmos_frame_t tx_frame,
  output logic tx_ready,
  output logic rx_valid,
  output cmos_pkg::cmos_frame_t rx_frame
);
  import cmos_pkg::*;
  int stall = 1;
  logic mute = 1'b0;
  int cnt = 0;
  logic [63:0] ans_data = 64'h0123_4567_89ab_cdef;
  assign tx_ready = tx_valid && (cnt >= stall);
  initial
  begin
    rx_valid = 1'b0;
    rx_frame = '1;
  end
  task automatic send(input cmos_frame_t f);
    @(posedge pclk);
    rx_valid <= 1'b1;
    rx_frame <= f;
    @(posedge pclk);
    rx_valid <= 1'b0;
    rx_frame <= ~f;
  endtask
  always @(posedge pclk)
  begin
    cnt <= (tx_valid && !tx_ready) ? cnt + 1 : 0;
    // Answer remote polls with a data frame unless muted
    if (tx_valid && tx_ready && tx_frame.rtr && !mute)
      fork
        send('{tx_frame.ext, tx_frame.id, 1'b0, tx_frame.dlc, ans_data});
      join_none
  end
endmodule // cmos_node

// File: bench/testbench.sv
// Self-checking bench of the message object scheduler
// Assumes cmos_pkg, cmos_regs.svh and the network model cmos_node
`timescale 1ns/1ps
`include "cmos_regs.svh"
module testbench;
  import cmos_pkg::*;
  localparam int MS = 10;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd_data;
  logic pready, pslverr, tx_valid, tx_ready, rx_valid, irq, err;
  cmos_frame_t tx_frame, rx_frame, got;
  int n_errors = 0, samples_checked = 0, cyc = 0, t0;
  logic [31:0] seed = 32'd73403;
  logic [63:0] d1, d2, d3;
  always #10 pclk = ~pclk;
  cmos_core #(.MS_CYCLES(MS)) i_cmos_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_valid(rx_valid), .rx_frame(rx_frame), .tx_valid(tx_valid), .tx_frame(tx_frame), .tx_ready(tx_ready),
    .irq(irq));
  cmos_node i_cmos_node (.pclk(pclk), .tx_valid(tx_valid), .tx_frame(tx_frame), .tx_ready(tx_ready),
    .rx_valid(rx_valid), .rx_frame(rx_frame));
  function automatic logic [63:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    rnd[63:32] = seed;
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    rnd[31:0] = seed ^ 32'h5a5a_5a5a;
  endfunction
  function automatic cmos_frame_t fr(input logic rtr, input logic [3:0] dlc, input logic [63:0] d);
    return '{1'b0, 29'h123, rtr, dlc, d};
  endfunction
  task automatic print_verdict();
    $display("errors %0d, checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [80:0] g, input logic [80:0] e, input string what);
    samples_checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_data = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, '0);
    chk(rd_data & m, e, "register read");
  endtask
  task automatic wr_data(input logic [63:0] d);
    apb(1'b1, `CMOS_WLO, d[31:0]);
    apb(1'b1, `CMOS_WHI, d[63:32]);
  endtask
  task automatic wait_tx();
    int k;
    for (k = 0; k < 500; k++)
    begin
      @(posedge pclk);
      if (tx_valid === 1'b1 && tx_ready === 1'b1)
        break;
    end
    got = tx_frame;
    chk(k < 500, 1, "transmit wait");
  endtask
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      n_errors++;
      print_verdict();
    end
  end
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(`CMOS_CFG, 32'h7ff, 32'h448);
    apb(1'b0, 12'h030, '0);
    chk({err, rd_data}, {1'b1, 32'h0}, "unmapped");
    for (int t = 0; t < 7; t++)
    begin
      apb(1'b1, `CMOS_CTRL, t);
      rd(`CMOS_CTRL, 32'h7, t);
    end
    // Unsolicited receive, duplicates, overflow, watchdog
    apb(1'b1, `CMOS_ID, 32'h0000_0123);
    apb(1'b1, `CMOS_CFG, 32'h0000_0228);
    apb(1'b1, `CMOS_IMASK, 32'h0000_0001);
    apb(1'b1, `CMOS_CTRL, 32'h0000_0030);
    d1 = rnd();
    d2 = rnd();
    d3 = rnd();
    i_cmos_node.send(fr(1'b0, 4'd8, d1));
    i_cmos_node.send('{1'b0, 29'h124, 1'b0, 4'd8, d2});
    i_cmos_node.send(fr(1'b1, 4'd8, '0));
    rd(`CMOS_STAT, 32'h77, 32'h01);
    chk({irq, tx_valid}, 2'b10, "irq and silence");
    apb(1'b1, `CMOS_ISTAT, 32'h3f);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b0, "irq cleared");
    apb(1'b1, `CMOS_CTRL, 32'h0000_0038);
    i_cmos_node.send(fr(1'b0, 4'd8, d1));
    i_cmos_node.send(fr(1'b0, 4'd8, d2));
    i_cmos_node.send(fr(1'b0, 4'd8, d3));
    rd(`CMOS_STAT, 32'h7, 32'h2);
    rd(`CMOS_ISTAT, 32'h8, 32'h8);
    rd(`CMOS_RLO, '1, d1[31:0]);
    rd(`CMOS_RHI, '1, d1[63:32]);
    apb(1'b1, `CMOS_PERIOD, 32'd3);
    apb(1'b1, `CMOS_ISTAT, 32'h3f);
    repeat (12)
    begin
      i_cmos_node.send(fr(1'b0, 4'd8, d2));
      repeat (6) @(posedge pclk);
    end
    rd(`CMOS_ISTAT, 32'h4, 32'h0);
    repeat (50) @(posedge pclk);
    rd(`CMOS_ISTAT, 32'h4, 32'h4);
    rd(`CMOS_RLO, '1, d2[31:0]);
    rd(`CMOS_RHI, '1, d2[63:32]);
    // Periodic transmit
    apb(1'b1, `CMOS_CFG, 32'h0000_0445);
    apb(1'b1, `CMOS_PERIOD, 32'd2);
    apb(1'b1, `CMOS_CTRL, 32'h0000_0023);
    apb(1'b1, `CMOS_ISTAT, 32'h3f);
    repeat (60) @(posedge pclk);
    rd(`CMOS_ISTAT, 32'h22, 32'h0);
    d1 = rnd();
    wr_data(d1);
    wait_tx();
    chk(got, fr(1'b0, 4'd5, d1), "first frame");
    t0 = cyc;
    wait_tx();
    chk(got, fr(1'b0, 4'd5, d1), "repeat frame");
    chk(cyc - t0, 2 * MS, "period gap");
    apb(1'b1, `CMOS_CTRL, 32'h0000_0033);
    d2 = rnd();
    wr_data(d2);
    i_cmos_node.send(fr(1'b1, 4'd8, '0));
    wait_tx();
    chk(got, fr(1'b0, 4'd5, d1), "remote answer");
    wait_tx();
    chk(got, fr(1'b0, 4'd5, d2), "next frame");
    apb(1'b1, `CMOS_PERIOD, 32'd0);
    repeat (25) @(posedge pclk);
    rd(`CMOS_ISTAT, 32'h20, 32'h20);
    // Poll on request with minimum gap
    apb(1'b1, `CMOS_CFG, 32'h0000_0443);
    apb(1'b1, `CMOS_PERIOD, 32'd2);
    apb(1'b1, `CMOS_CTRL, 32'h0000_0022);
    i_cmos_node.ans_data = rnd();
    i_cmos_node.stall = 3;
    apb(1'b1, `CMOS_WHI, 32'h0);
    wait_tx();
    chk({got.rtr, got.dlc, got.id}, {1'b1, 4'd3, 29'h123}, "poll frame");
    t0 = cyc;
    apb(1'b1, `CMOS_WHI, 32'h0);
    wait_tx();
    chk(cyc - t0 >= 2 * MS, 1, "minimum gap");
    rd(`CMOS_RLO, '1, i_cmos_node.ans_data[31:0]);
    // Answer-only and write queue depth
    apb(1'b1, `CMOS_CTRL, 32'h0000_0025);
    apb(1'b1, `CMOS_ISTAT, 32'h3f);
    d3 = rnd();
    wr_data(d3);
    repeat (4) apb(1'b1, `CMOS_WHI, d3[63:32]);
    repeat (40) @(posedge pclk);
    rd(`CMOS_STAT, 32'h70, 32'h40);
    rd(`CMOS_ISTAT, 32'h12, 32'h10);
    i_cmos_node.send(fr(1'b1, 4'd8, '0));
    wait_tx();
    chk(got, fr(1'b0, 4'd3, d3), "answer frame");
    apb(1'b1, `CMOS_CTRL, 32'h0000_0024);
    i_cmos_node.send(fr(1'b1, 4'd8, '0));
    repeat (10) @(posedge pclk);
    chk(tx_valid, 1'b0, "remote ignored");
    // Periodic remote poll, hold when unanswered
    apb(1'b1, `CMOS_CTRL, 32'h0000_0021);
    wait_tx();
    chk({got.rtr, got.dlc, got.id}, {1'b1, 4'd3, 29'h123}, "periodic poll");
    t0 = cyc;
    repeat (2) @(posedge pclk);
    rd(`CMOS_STAT, 32'h307, 32'h003);
    wait_tx();
    chk(cyc - t0, 2 * MS, "poll period");
    repeat (4) @(posedge pclk);
    i_cmos_node.mute = 1'b1;
    wait_tx();
    repeat (20) @(posedge pclk);
    rd(`CMOS_STAT, 32'h300, 32'h300);
    apb(1'b1, `CMOS_ISTAT, 32'h3f);
    repeat (50) @(posedge pclk);
    rd(`CMOS_ISTAT, 32'h2, 32'h0);
    i_cmos_node.mute = 1'b0;
    i_cmos_node.send(fr(1'b0, 4'd8, d1));
    wait_tx();
    chk(got.rtr, 1'b1, "poll resumed");
    // Waveform replays the queued frames in order
    apb(1'b1, `CMOS_CTRL, 32'h0000_0006);
    wr_data(d2);
    apb(1'b1, `CMOS_CTRL, 32'h0000_0026);
    apb(1'b1, `CMOS_ISTAT, 32'h3f);
    apb(1'b1, `CMOS_WHI, 32'h0);
    rd(`CMOS_ISTAT, 32'h10, 32'h10);
    for (int k = 0; k < 5; k++)
    begin
      wait_tx();
      chk(got, fr(1'b0, 4'd3, (k == 3) ? d2 : d3), "waveform frame");
    end
    print_verdict();
  end
endmodule // testbench
